// *** common/aspc_pkg.sv ***
// Constants, register map and state types of the asynchronous serial port.
package aspc_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_DATA = 3'h1;
    localparam logic [2:0] REG_OWN_ADDR = 3'h2;
    localparam logic [2:0] REG_ADDR_MASK = 3'h3;
    localparam logic [2:0] REG_AUX = 3'h4;
    localparam logic [2:0] REG_IRQ_ST = 3'h5;
    localparam logic [2:0] REG_IRQ_MASK = 3'h6;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_MPF = 5;
    localparam int CTL_REN = 4;
    localparam int CTL_TB8 = 3;
    localparam int CTL_RB8 = 2;
    localparam int CTL_TI = 1;
    localparam int CTL_RI = 0;
    localparam int AUX_ERR_ACC = 0;
    localparam int AUX_DOUBLE = 1;
    localparam int AUX_CLK6 = 2;
    localparam int IRQ_TX = 0;
    localparam int IRQ_RX = 1;
    localparam int IRQ_FE = 2;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] OWN_ADDR_RST = 8'h00;
    localparam logic [7:0] ADDR_MASK_RST = 8'h00;
    localparam logic [2:0] AUX_RST = 3'h0;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // ---------------------------------------------------------------
    // Timing counts
    // ---------------------------------------------------------------
    localparam logic [6:0] BIT_DIV_12C = 7'h40;
    localparam logic [6:0] BIT_DIV_6C = 7'h20;
    localparam int OS_LOG2 = 4;
    localparam logic [3:0] OS_SAMPLE = 4'h7;
    localparam logic [3:0] OS_LAST = 4'hf;
    localparam logic [3:0] SH_DIV_12C = 4'hc;
    localparam logic [3:0] SH_DIV_6C = 4'h6;
    localparam logic [3:0] SH_LAST_BIT = 4'h7;
    localparam logic [3:0] STOP_IDX_8 = 4'h9;
    localparam logic [3:0] STOP_IDX_9 = 4'ha;
    localparam logic [3:0] NINTH_IDX = 4'h9;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SHIFT = 2'b00,
        MODE_UART8 = 2'b01,
        MODE_UART9_FIXED = 2'b10,
        MODE_UART9_VAR = 2'b11
    } aspc_mode_e;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_UART = 2'b01,
        TX_SHIFT = 2'b10
    } aspc_tx_e;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_UART = 2'b01,
        RX_SHIFT = 2'b10
    } aspc_rx_e;

endpackage

// *** rtl/aspc_pin_sync.sv ***
// Three-stage synchroniser that passes a pin level once two stages agree.
`timescale 1ns/10ps
`default_nettype none
module aspc_pin_sync (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    output logic level_o
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            level_reg <= 1'b1;
        end else if (s2_reg == s3_reg) begin
            level_reg <= s3_reg;
        end
    end

    assign level_o = level_reg;
endmodule
`default_nettype wire

// *** rtl/aspc_top.sv ***
// Asynchronous serial port: mode control, bit timing, transmit, receive, address filter.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Two mode bits select one of four modes.
// - Mode 2 divides oscillator, doubling picks divisor.
// - Full duplex in modes 1 to 3; modes 1, 3 use timer overflow.
// - Ninth bit, or mode 1 stop bit, captured.
// - Transmit done at stop start or bit eight.
// - Transmit done flag cleared only by software.
// - Receive done at stop bit or bit eight.
// - Stop error sticky, visible with access bit.
// - Given address is own address AND mask.
// - Broadcast address is own address OR mask.
module aspc_top (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [aspc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic t1_ovf_i,
    input wire logic rxd_i,
    output logic rxd_o,
    output logic rxd_oe_o,
    output logic txd_o,
    output logic irq_o
);
    import aspc_pkg::*;

    function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] pat, input logic [7:0] care);
        return ((b ^ pat) & care) == 8'h00;
    endfunction

    logic mode_hi_reg, mode_lo_reg, mpf_reg, ren_reg, tb8_reg;
    logic ti_reg, ri_reg, rb8_reg, fe_reg;
    logic err_acc_reg, dbl_reg, clk6_reg;
    logic [7:0] own_addr_reg, addr_mask_reg, rx_data_reg, rdata_reg, rd_mux;
    logic [2:0] irq_st_reg, irq_mask_reg, os_cnt_reg, os_div;
    logic t1_pre_reg, os_tick;
    logic [3:0] sh_cnt_reg, sh_div, sh_half;
    logic sh_wrap, sh_mid, sh_restart;
    aspc_mode_e cur_mode;
    aspc_tx_e tx_state_reg;
    aspc_rx_e rx_state_reg;
    logic [10:0] tx_frame_reg;
    logic [3:0] tx_idx_reg, tx_phase_reg, rx_idx_reg, rx_phase_reg, stop_idx;
    logic [7:0] rx_shift_reg;
    logic rx_bit9_reg, rx_line, rx_prev_reg, nine;
    logic wr_ctrl, wr_data, ti_set, ri_set, fe_set, rx_stop_evt, addr_ok, rx_accept;
    logic txd_reg, rxd_out_reg, rxd_oe_reg;

    // ---------------------------------------------------------------
    // Register writes and flags
    // ---------------------------------------------------------------
    assign wr_ctrl = wr_i && (addr_i == REG_CTRL);
    assign wr_data = wr_i && (addr_i == REG_DATA);
    assign cur_mode = aspc_mode_e'({mode_hi_reg, mode_lo_reg});
    assign nine = mode_hi_reg;
    assign stop_idx = nine ? STOP_IDX_9 : STOP_IDX_8;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_hi_reg <= CTRL_RST[CTL_MODE_HI];
            mode_lo_reg <= CTRL_RST[CTL_MODE_LO];
            mpf_reg <= CTRL_RST[CTL_MPF];
            ren_reg <= CTRL_RST[CTL_REN];
            tb8_reg <= CTRL_RST[CTL_TB8];
        end else if (wr_ctrl) begin
            if (!err_acc_reg) begin
                mode_hi_reg <= wdata_i[CTL_MODE_HI];
            end
            mode_lo_reg <= wdata_i[CTL_MODE_LO];
            mpf_reg <= wdata_i[CTL_MPF];
            ren_reg <= wdata_i[CTL_REN];
            tb8_reg <= wdata_i[CTL_TB8];
        end
    end

    // Hardware sets win over a software write in the same cycle.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ti_reg <= CTRL_RST[CTL_TI];
            ri_reg <= CTRL_RST[CTL_RI];
            rb8_reg <= CTRL_RST[CTL_RB8];
        end else begin
            if (ti_set) begin
                ti_reg <= 1'b1;
            end else if (wr_ctrl) begin
                ti_reg <= wdata_i[CTL_TI];
            end
            if (ri_set) begin
                ri_reg <= 1'b1;
            end else if (wr_ctrl) begin
                ri_reg <= wdata_i[CTL_RI];
            end
            if (rx_accept) begin
                rb8_reg <= nine ? rx_bit9_reg : rx_line;
            end else if (wr_ctrl) begin
                rb8_reg <= wdata_i[CTL_RB8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fe_reg <= CTRL_RST[CTL_MODE_HI];
        end else if (fe_set) begin
            fe_reg <= 1'b1;
        end else if (wr_ctrl && err_acc_reg) begin
            fe_reg <= wdata_i[CTL_MODE_HI];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            own_addr_reg <= OWN_ADDR_RST;
            addr_mask_reg <= ADDR_MASK_RST;
            {clk6_reg, dbl_reg, err_acc_reg} <= AUX_RST;
            irq_mask_reg <= IRQ_MASK_RST;
        end else if (wr_i) begin
            if (addr_i == REG_OWN_ADDR) begin
                own_addr_reg <= wdata_i;
            end
            if (addr_i == REG_ADDR_MASK) begin
                addr_mask_reg <= wdata_i;
            end
            if (addr_i == REG_AUX) begin
                clk6_reg <= wdata_i[AUX_CLK6];
                dbl_reg <= wdata_i[AUX_DOUBLE];
                err_acc_reg <= wdata_i[AUX_ERR_ACC];
            end
            if (addr_i == REG_IRQ_MASK) begin
                irq_mask_reg <= wdata_i[2:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // Interrupt status, write one to clear
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_st_reg <= 3'h0;
        end else begin
            irq_st_reg <= (irq_st_reg & ~((wr_i && addr_i == REG_IRQ_ST) ? wdata_i[2:0] : 3'h0))
                | {fe_set, ri_set, ti_set};
        end
    end
    assign irq_o = |(irq_st_reg & irq_mask_reg);

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    always_comb begin
        unique case (addr_i)
            REG_CTRL: rd_mux = {err_acc_reg ? fe_reg : mode_hi_reg, mode_lo_reg, mpf_reg, ren_reg,
                tb8_reg, rb8_reg, ti_reg, ri_reg};
            REG_DATA: rd_mux = rx_data_reg;
            REG_OWN_ADDR: rd_mux = own_addr_reg;
            REG_ADDR_MASK: rd_mux = addr_mask_reg;
            REG_AUX: rd_mux = {5'h00, clk6_reg, dbl_reg, err_acc_reg};
            REG_IRQ_ST: rd_mux = {5'h00, irq_st_reg};
            REG_IRQ_MASK: rd_mux = {5'h00, irq_mask_reg};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rd_i ? rd_mux : 8'h00;
        end
    end
    assign rdata_o = rdata_reg;

    // ---------------------------------------------------------------
    // Bit timing: sixteen sample ticks per bit in modes 1 to 3
    // ---------------------------------------------------------------
    always_comb begin
        logic [6:0] b;
        b = clk6_reg ? BIT_DIV_6C : BIT_DIV_12C;
        if (dbl_reg) begin
            b = b >> 1;
        end
        b = b >> OS_LOG2;
        os_div = b[2:0];
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            os_cnt_reg <= 3'h0;
            t1_pre_reg <= 1'b0;
        end else begin
            os_cnt_reg <= (os_cnt_reg == os_div - 3'h1) ? 3'h0 : os_cnt_reg + 3'h1;
            if (t1_ovf_i) begin
                t1_pre_reg <= ~t1_pre_reg;
            end
        end
    end

    always_comb begin
        if (cur_mode == MODE_UART9_FIXED) begin
            os_tick = (os_cnt_reg == os_div - 3'h1);
        end else begin
            os_tick = t1_ovf_i && (dbl_reg || t1_pre_reg);
        end
    end

    // Shift clock of mode 0, restarted so that every frame begins on a full period.
    assign sh_div = clk6_reg ? SH_DIV_6C : SH_DIV_12C;
    assign sh_half = sh_div >> 1;
    assign sh_wrap = (sh_cnt_reg == sh_div - 4'h1);
    assign sh_mid = (sh_cnt_reg == sh_half - 4'h1);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || sh_restart || sh_wrap) begin
            sh_cnt_reg <= 4'h0;
        end else begin
            sh_cnt_reg <= sh_cnt_reg + 4'h1;
        end
    end

    // ---------------------------------------------------------------
    // Transmitter; a data write while busy is ignored
    // ---------------------------------------------------------------
    assign sh_restart = (tx_state_reg == TX_IDLE && rx_state_reg == RX_IDLE && cur_mode == MODE_SHIFT)
        && (wr_data || (ren_reg && !ri_reg));
    assign ti_set = (tx_state_reg == TX_UART && os_tick && tx_phase_reg == OS_LAST
        && tx_idx_reg == stop_idx - 4'h1)
        || (tx_state_reg == TX_SHIFT && sh_wrap && tx_idx_reg == SH_LAST_BIT);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_state_reg <= TX_IDLE;
            tx_frame_reg <= 11'h7ff;
            tx_idx_reg <= 4'h0;
            tx_phase_reg <= 4'h0;
        end else begin
            unique case (tx_state_reg)
                TX_IDLE: begin
                    tx_idx_reg <= 4'h0;
                    tx_phase_reg <= 4'h0;
                    if (wr_data && cur_mode != MODE_SHIFT) begin
                        tx_state_reg <= TX_UART;
                        tx_frame_reg <= {1'b1, nine ? tb8_reg : 1'b1, wdata_i, 1'b0};
                    end else if (wr_data && rx_state_reg == RX_IDLE) begin
                        tx_state_reg <= TX_SHIFT;
                        tx_frame_reg <= {3'h7, wdata_i};
                    end
                end
                TX_UART: begin
                    if (os_tick) begin
                        tx_phase_reg <= tx_phase_reg + 4'h1;
                        if (tx_phase_reg == OS_LAST) begin
                            tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
                            tx_idx_reg <= tx_idx_reg + 4'h1;
                            if (tx_idx_reg == stop_idx) begin
                                tx_state_reg <= TX_IDLE;
                            end
                        end
                    end
                end
                TX_SHIFT: begin
                    if (sh_wrap) begin
                        tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
                        tx_idx_reg <= tx_idx_reg + 4'h1;
                        if (tx_idx_reg == SH_LAST_BIT) begin
                            tx_state_reg <= TX_IDLE;
                        end
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Receiver, independent of the transmitter except in mode 0, where each waits for the other to go idle
    // ---------------------------------------------------------------
    aspc_pin_sync u_rxd_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(rxd_i),
        .level_o(rx_line)
    );

    assign rx_stop_evt = rx_state_reg == RX_UART && os_tick && rx_phase_reg == OS_SAMPLE
        && rx_idx_reg == stop_idx;
    assign addr_ok = addr_hit(rx_shift_reg, own_addr_reg & addr_mask_reg, addr_mask_reg)
        || addr_hit(rx_shift_reg, own_addr_reg | addr_mask_reg, own_addr_reg | addr_mask_reg);
    assign rx_accept = rx_stop_evt && !ri_reg
        && (!mpf_reg || (nine ? (rx_bit9_reg && addr_ok) : rx_line));
    assign fe_set = rx_stop_evt && !rx_line;
    assign ri_set = rx_accept
        || (rx_state_reg == RX_SHIFT && sh_wrap && rx_idx_reg == SH_LAST_BIT);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_state_reg <= RX_IDLE;
            rx_prev_reg <= 1'b1;
            rx_idx_reg <= 4'h0;
            rx_phase_reg <= 4'h0;
            rx_shift_reg <= 8'h00;
            rx_bit9_reg <= 1'b0;
            rx_data_reg <= 8'h00;
        end else begin
            rx_prev_reg <= rx_line;
            if (ri_set) begin
                rx_data_reg <= rx_shift_reg;
            end
            unique case (rx_state_reg)
                RX_IDLE: begin
                    rx_idx_reg <= 4'h0;
                    rx_phase_reg <= 4'h0;
                    if (ren_reg && cur_mode != MODE_SHIFT && rx_prev_reg && !rx_line) begin
                        rx_state_reg <= RX_UART;
                    end else if (sh_restart && !wr_data) begin
                        rx_state_reg <= RX_SHIFT;
                    end
                end
                RX_UART: begin
                    if (os_tick) begin
                        rx_phase_reg <= rx_phase_reg + 4'h1;
                        if (rx_phase_reg == OS_LAST) begin
                            rx_idx_reg <= rx_idx_reg + 4'h1;
                        end
                        if (rx_phase_reg == OS_SAMPLE) begin
                            if ((rx_idx_reg == 4'h0 && rx_line) || rx_idx_reg == stop_idx) begin
                                rx_state_reg <= RX_IDLE;
                            end else if (nine && rx_idx_reg == NINTH_IDX) begin
                                rx_bit9_reg <= rx_line;
                            end else if (rx_idx_reg != 4'h0) begin
                                rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
                            end
                        end
                    end
                end
                RX_SHIFT: begin
                    if (sh_mid) begin
                        rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
                    end
                    if (sh_wrap) begin
                        rx_idx_reg <= rx_idx_reg + 4'h1;
                        if (rx_idx_reg == SH_LAST_BIT) begin
                            rx_state_reg <= RX_IDLE;
                        end
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Pin drivers; in mode 0 the transmit pin carries the shift clock
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            txd_reg <= 1'b1;
            rxd_out_reg <= 1'b1;
            rxd_oe_reg <= 1'b0;
        end else begin
            if (tx_state_reg == TX_SHIFT || rx_state_reg == RX_SHIFT) begin
                txd_reg <= sh_cnt_reg >= sh_half;
            end else begin
                txd_reg <= (tx_state_reg == TX_UART) ? tx_frame_reg[0] : 1'b1;
            end
            rxd_out_reg <= tx_frame_reg[0];
            rxd_oe_reg <= (tx_state_reg == TX_SHIFT);
        end
    end
    assign txd_o = txd_reg;
    assign rxd_o = rxd_out_reg;
    assign rxd_oe_o = rxd_oe_reg;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    // A register write may change the divider, so the rate is only checked across a window free of writes.
    sequence s_m2_quiet;
        (os_tick && cur_mode == MODE_UART9_FIXED && !clk6_reg && !dbl_reg && !wr_i) ##1 (!wr_i) [*3];
    endsequence

    property p_mode0_drive;
        @(posedge clk_i) disable iff (!rst_n_i) $rose(rxd_oe_o) |-> $past(cur_mode) == MODE_SHIFT;
    endproperty
    a_mode0_drive: assert property (p_mode0_drive) else $error("data pin driven outside mode 0");

    property p_m2_rate;
        @(posedge clk_i) disable iff (!rst_n_i)
            s_m2_quiet |=> os_tick && !$past(os_tick) && !$past(os_tick, 2) && !$past(os_tick, 3);
    endproperty
    a_m2_rate: assert property (p_m2_rate) else $error("mode 2 sample rate wrong");

    property p_t1_rate;
        @(posedge clk_i) disable iff (!rst_n_i)
            (os_tick && mode_lo_reg) |-> t1_ovf_i && (dbl_reg || t1_pre_reg);
    endproperty
    a_t1_rate: assert property (p_t1_rate) else $error("variable rate not from timer");

    property p_rb8_stop;
        @(posedge clk_i) disable iff (!rst_n_i)
            (rx_accept && cur_mode == MODE_UART8 && !wr_ctrl) |=> rb8_reg == $past(rx_line);
    endproperty
    a_rb8_stop: assert property (p_rb8_stop) else $error("mode 1 stop bit not captured");

    property p_ti_stop;
        @(posedge clk_i) disable iff (!rst_n_i)
            (ti_set && tx_state_reg == TX_UART) |-> ##2 txd_o;
    endproperty
    a_ti_stop: assert property (p_ti_stop) else $error("transmit done not at stop bit");

    property p_ti_hold;
        @(posedge clk_i) disable iff (!rst_n_i) (ti_reg && !wr_ctrl) |=> ti_reg;
    endproperty
    a_ti_hold: assert property (p_ti_hold) else $error("transmit done cleared by hardware");

    property p_ri_mode0;
        @(posedge clk_i) disable iff (!rst_n_i)
            (ri_set && rx_state_reg == RX_SHIFT) |-> sh_wrap && rx_idx_reg == SH_LAST_BIT;
    endproperty
    a_ri_mode0: assert property (p_ri_mode0) else $error("mode 0 receive done early");

    property p_ri_filter;
        @(posedge clk_i) disable iff (!rst_n_i)
            (ri_set && mpf_reg && nine && rx_state_reg == RX_UART) |-> rx_bit9_reg && addr_ok;
    endproperty
    a_ri_filter: assert property (p_ri_filter) else $error("filtered frame accepted");

    property p_fe_hold;
        @(posedge clk_i) disable iff (!rst_n_i) (fe_reg && !(wr_ctrl && err_acc_reg)) |=> fe_reg;
    endproperty
    a_fe_hold: assert property (p_fe_hold) else $error("stop error lost");

    property p_rst_addr;
        @(posedge clk_i) disable iff (!rst_n_i)
            $rose(rst_n_i) |-> own_addr_reg == 8'h00 && addr_mask_reg == 8'h00 && addr_ok;
    endproperty
    a_rst_addr: assert property (p_rst_addr) else $error("address not cleared at reset");
endmodule
`default_nettype wire

// *** verif/aspc_remote_node.sv ***
// Remote serial node: sends frames into the port and captures frames it sends.
`timescale 1ns/10ps
`default_nettype none
module aspc_remote_node #(parameter int BIT = 16) (
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o,
    output logic [8:0] got_o
);
    initial rxd_o = 1'b1;
    initial got_o = 9'h000;
    // Start bit, nine bits LSB first, stop bit, then one idle bit time high.
    task automatic send(input logic [8:0] d, input logic stp);
        logic [11:0] f;
        f = {1'b1, stp, d, 1'b0};
        for (int i = 0; i < 12; i++) begin
            repeat (BIT) @(posedge clk_i) rxd_o <= f[i];
        end
    endtask
    // Samples each of the nine bits after the start bit in its middle, counted from the falling start edge.
    always begin
        @(negedge txd_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge clk_i);
            got_o[i] <= txd_i;
        end
    end
endmodule
`default_nettype wire

// *** verif/tb_aspc_top.sv ***
// Self-checking bench of the asynchronous serial port.
`timescale 1ns/10ps
`default_nettype none
module tb_aspc_top;
    import aspc_pkg::*;
    typedef struct {logic we; logic [2:0] a; logic [7:0] d; logic [7:0] e;} aspc_row_s;
    aspc_row_s rows[6] = '{'{0, 3'h0, 8'h00, 8'h00}, '{0, 3'h2, 8'h00, 8'h00}, '{0, 3'h3, 8'h00, 8'h00},
        '{1, 3'h7, 8'hff, 8'h00}, '{1, 3'h2, 8'h12, 8'h12}, '{1, 3'h3, 8'hff, 8'hff}};
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic t1_ovf_i = 1'b0;
    logic rxd_i, rxd_o, rxd_oe_o, txd_o, irq_o;
    logic [7:0] rdata_o, v;
    logic [8:0] got;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    aspc_top aspc_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .t1_ovf_i(t1_ovf_i), .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o),
        .txd_o(txd_o),
        .irq_o(irq_o));
    aspc_remote_node aspc_remote_node_i (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i), .got_o(got));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].we) begin
                wr(rows[i].a, rows[i].d);
            end
            rd(rows[i].a);
            chk(v, rows[i].e);
        end
        // Mode 2, 6-clock core, doubled rate: one bit every 16 clocks.
        wr(REG_AUX, 8'h06);
        wr(REG_IRQ_MASK, 8'h01);
        wr(REG_CTRL, 8'h88);
        wr(REG_DATA, 8'ha5);
        n = 0;
        while (irq_o !== 1'b1 && n < 400) begin
            @(posedge clk_i) #1 n++;
        end
        chk({7'h00, n inside {[158:168]}}, 8'h01);
        chk(got[7:0], 8'ha5);
        chk({7'h00, got[8]}, 8'h01);
        repeat (200) @(posedge clk_i);
        rd(REG_CTRL);
        chk(v, 8'h8a);
        wr(REG_IRQ_MASK, 8'h00);
        chk({7'h00, irq_o}, 8'h00);
        wr(REG_IRQ_MASK, 8'h01);
        chk({7'h00, irq_o}, 8'h01);
        wr(REG_IRQ_ST, 8'h01);
        chk({7'h00, irq_o}, 8'h00);
        // Own address 12 with full mask: given 12, broadcast ff.
        wr(REG_CTRL, 8'hb0);
        aspc_remote_node_i.send(9'h134, 1'b1);
        rd(REG_CTRL);
        chk(v & 8'h01, 8'h00);
        aspc_remote_node_i.send(9'h112, 1'b1);
        rd(REG_CTRL);
        chk(v, 8'hb5);
        rd(REG_DATA);
        chk(v, 8'h12);
        wr(REG_CTRL, 8'hb0);
        aspc_remote_node_i.send(9'h1ff, 1'b1);
        rd(REG_CTRL);
        chk(v & 8'h05, 8'h05);
        wr(REG_CTRL, 8'hb0);
        wr(REG_AUX, 8'h07);
        aspc_remote_node_i.send(9'h112, 1'b0);
        rd(REG_CTRL);
        chk(v & 8'h80, 8'h80);
        aspc_remote_node_i.send(9'h1ff, 1'b1);
        rd(REG_CTRL);
        chk(v & 8'h80, 8'h80);
        // Mode 2 at the slow 12-clock rate for a few sample ticks.
        wr(REG_AUX, 8'h00);
        repeat (8) @(posedge clk_i);
        // Mode 1 timed by the timer overflow, sending and receiving at once.
        wr(REG_AUX, 8'h06);
        wr(REG_CTRL, 8'h50);
        @(posedge clk_i) t1_ovf_i <= 1'b1;
        wr(REG_DATA, 8'h3c);
        aspc_remote_node_i.send(9'h1c3, 1'b1);
        rd(REG_CTRL);
        chk(v, 8'h57);
        rd(REG_DATA);
        chk(v, 8'hc3);
        chk(got[7:0], 8'h3c);
        chk({7'h00, got[8]}, 8'h01);
        // Mode 0: the port drives the data pin, then shifts in the idle line.
        wr(REG_CTRL, 8'h00);
        wr(REG_DATA, 8'h5a);
        @(posedge clk_i);
        #1;
        chk({6'h00, rxd_oe_o, rxd_o}, 8'h02);
        repeat (60) @(posedge clk_i);
        rd(REG_CTRL);
        chk(v, 8'h02);
        wr(REG_CTRL, 8'h10);
        repeat (60) @(posedge clk_i);
        rd(REG_DATA);
        chk(v, 8'hff);
        // A reset in mid-run clears the address registers again.
        @(posedge clk_i) rst_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(REG_OWN_ADDR);
        chk(v, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
